// ==== logic/timer_ctl.sv ====
// control and status bits of timers 0, 1 and 2 with an Avalon-MM slave
`timescale 1ns/1ps
`default_nettype none
`include "timer_ctl_defines.svh"

module timer_ctl (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // datapath and processor events
    input wire timer_ctl_pkg::timer_events_t events,
    input wire timer_ctl_pkg::vector_acks_t acks,
    // pins
    input wire logic ext_int_a_pin,
    input wire logic ext_int_b_pin,
    input wire logic t2_trigger_input,
    // controls to the counters and serial port
    output logic t0_run,
    output logic t1_run,
    output logic t2_run,
    output logic t2_counter_mode,
    output logic t2_capture_pulse,
    output logic t2_reload_pulse,
    output logic rx_baud_tick,
    output logic tx_baud_tick,
    // interrupt requests
    output logic ext_int_a_req,
    output logic ext_int_b_req,
    output logic t2_irq_req,
    output logic irq
);

    logic [7:0] tc_q, t2c_q;
    logic [1:0] t2m_q;
    logic [`IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_set;
    logic [2:0] sync1_q, sync2_q, prev_q;
    logic [31:0] rdata_q;
    logic wait_q, wr_en, wr_tc, wr_t2c, baud_mode;
    logic exta_fall, extb_edge, trig_fall, exta_set, extb_set;
    logic t2_ovf_set, t2_ext_set, t2_ext_tog;
    logic run0_q, run1_q, run2_q, cnt2_q, cap_q, rel_q;
    logic rx_tick_q, tx_tick_q, exta_req_q, extb_req_q, t2_req_q, irq_q;
    timer_ctl_pkg::t2_mode_t t2_mode;

    // bus slave: one wait cycle, then the request is accepted
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= ~((read | write) & wait_q);
        end
    end

    assign wr_en = write & ~wait_q;
    assign wr_tc = wr_en & (address == `ADDR_TIMER_CONTROL);
    assign wr_t2c = wr_en & (address == `ADDR_TIMER2_CONTROL);

    // read data is latched in the wait cycle; unmapped reads give zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_q <= 32'h0;
        end else if (read & wait_q) begin
            case (address)
                `ADDR_TIMER_CONTROL: rdata_q <= {24'h0, tc_q};
                `ADDR_TIMER2_CONTROL: rdata_q <= {24'h0, t2c_q};
                `ADDR_T2_MODE: rdata_q <= {30'h0, t2m_q};
                `ADDR_IRQ_STATUS: rdata_q <= {26'h0, irq_stat_q};
                `ADDR_IRQ_MASK: rdata_q <= {26'h0, irq_mask_q};
                default: rdata_q <= 32'h0;
            endcase
        end
    end

    // pin synchronisers; edges are read only after the second stage
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync1_q <= 3'h7;
            sync2_q <= 3'h7;
            prev_q <= 3'h7;
        end else begin
            sync1_q <= {t2_trigger_input, ext_int_b_pin, ext_int_a_pin};
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    assign exta_fall = prev_q[0] & ~sync2_q[0];
    assign extb_edge = prev_q[1] ^ sync2_q[1];
    assign trig_fall = prev_q[2] & ~sync2_q[2];

    always_comb begin
        if (t2c_q[`T2_CAP_SEL]) begin
            t2_mode = timer_ctl_pkg::T2_MODE_CAPTURE;
        end else if (baud_mode | t2m_q[`T2M_CLKOUT]) begin
            t2_mode = timer_ctl_pkg::T2_MODE_OTHER;
        end else if (t2m_q[`T2M_UPDOWN]) begin
            t2_mode = timer_ctl_pkg::T2_MODE_RELOAD_UD;
        end else begin
            t2_mode = timer_ctl_pkg::T2_MODE_RELOAD;
        end
    end

    assign baud_mode = t2c_q[`T2_RX_SEL] | t2c_q[`T2_TX_SEL];
    // no overflow flag in baud or clock-out mode
    assign t2_ovf_set = events.t2_ovf & ~baud_mode & ~t2m_q[`T2M_CLKOUT];
    // up/down reload ignores the trigger input, whether enabled or not
    assign t2_ext_set = trig_fall & t2c_q[`T2_TRIG_EN]
        & (t2_mode != timer_ctl_pkg::T2_MODE_RELOAD_UD);
    assign t2_ext_tog = (t2_mode == timer_ctl_pkg::T2_MODE_RELOAD_UD)
        & (events.t2_ovf | events.t2_udf);
    assign exta_set = tc_q[`TC_EXTA_TYPE] ? exta_fall : ~sync2_q[0];
    assign extb_set = tc_q[`TC_EXTB_TYPE] ? extb_edge : ~sync2_q[1];

    // timer_control: hardware sets win over vector clears and writes
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tc_q <= `RST_TC;
        end else begin
            if (wr_tc) begin
                tc_q <= writedata[7:0];
            end
            if (events.t1_ovf) begin
                tc_q[`TC_T1_OVF] <= 1'b1;
            end else if (acks.t1_ack) begin
                tc_q[`TC_T1_OVF] <= 1'b0;
            end
            if (events.t0_ovf) begin
                tc_q[`TC_T0_OVF] <= 1'b1;
            end else if (acks.t0_ack) begin
                tc_q[`TC_T0_OVF] <= 1'b0;
            end
            if (!tc_q[`TC_EXTA_TYPE]) begin
                tc_q[`TC_EXTA_FLAG] <= exta_set;
            end else if (exta_set) begin
                tc_q[`TC_EXTA_FLAG] <= 1'b1;
            end else if (acks.exta_ack) begin
                tc_q[`TC_EXTA_FLAG] <= 1'b0;
            end
            if (!tc_q[`TC_EXTB_TYPE]) begin
                tc_q[`TC_EXTB_FLAG] <= extb_set;
            end else if (extb_set) begin
                tc_q[`TC_EXTB_FLAG] <= 1'b1;
            end else if (acks.extb_ack) begin
                tc_q[`TC_EXTB_FLAG] <= 1'b0;
            end
        end
    end

    // timer2_control: overflow flag cleared only by software writing zero; external flag also toggles in up/down reload
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            t2c_q <= `RST_T2C;
        end else begin
            if (wr_t2c) begin
                t2c_q <= writedata[7:0];
            end
            if (t2_ovf_set) begin
                t2c_q[`T2_OVF] <= 1'b1;
            end
            if (t2_ext_set) begin
                t2c_q[`T2_EXT] <= 1'b1;
            end else if (t2_ext_tog) begin
                t2c_q[`T2_EXT] <= ~t2c_q[`T2_EXT];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            t2m_q <= `RST_T2M;
        end else if (wr_en && address == `ADDR_T2_MODE) begin
            t2m_q <= writedata[1:0];
        end
    end

    // interrupt status: sticky, write one to clear, set wins
    assign irq_set[`IRQ_T0] = events.t0_ovf;
    assign irq_set[`IRQ_T1] = events.t1_ovf;
    assign irq_set[`IRQ_T2_OVF] = t2_ovf_set;
    assign irq_set[`IRQ_T2_EXT] = t2_ext_set;
    assign irq_set[`IRQ_EXTA] = exta_set;
    assign irq_set[`IRQ_EXTB] = extb_set;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_stat_q <= `RST_IRQ;
        end else if (wr_en && address == `ADDR_IRQ_STATUS) begin
            irq_stat_q <= (irq_stat_q & ~writedata[`IRQ_W-1:0]) | irq_set;
        end else begin
            irq_stat_q <= irq_stat_q | irq_set;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_mask_q <= `RST_IRQ;
        end else if (wr_en && address == `ADDR_IRQ_MASK) begin
            irq_mask_q <= writedata[`IRQ_W-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    // controls to the counters, registered for clean outputs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            run0_q <= 1'b0;
            run1_q <= 1'b0;
            run2_q <= 1'b0;
            cnt2_q <= 1'b0;
        end else begin
            run0_q <= tc_q[`TC_T0_RUN];
            run1_q <= tc_q[`TC_T1_RUN];
            run2_q <= t2c_q[`T2_RUN];
            cnt2_q <= t2c_q[`T2_CNT_SEL];
        end
    end

    // capture and reload strobes follow the synchronised trigger fall by one cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cap_q <= 1'b0;
            rel_q <= 1'b0;
        end else begin
            // capture or reload on enabled fall
            cap_q <= t2_ext_set & (t2_mode == timer_ctl_pkg::T2_MODE_CAPTURE);
            rel_q <= t2_ext_set & (t2_mode == timer_ctl_pkg::T2_MODE_RELOAD);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_tick_q <= 1'b0;
            tx_tick_q <= 1'b0;
        end else begin
            rx_tick_q <= t2c_q[`T2_RX_SEL] ? events.t2_ovf : events.t1_ovf;
            tx_tick_q <= t2c_q[`T2_TX_SEL] ? events.t2_ovf : events.t1_ovf;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            exta_req_q <= 1'b0;
            extb_req_q <= 1'b0;
            t2_req_q <= 1'b0;
        end else begin
            exta_req_q <= tc_q[`TC_EXTA_FLAG];
            extb_req_q <= tc_q[`TC_EXTB_FLAG];
            t2_req_q <= t2c_q[`T2_OVF] | t2c_q[`T2_EXT];
        end
    end

    assign readdata = rdata_q;
    assign waitrequest = wait_q;
    assign t0_run = run0_q;
    assign t1_run = run1_q;
    assign t2_run = run2_q;
    assign t2_counter_mode = cnt2_q;
    assign t2_capture_pulse = cap_q;
    assign t2_reload_pulse = rel_q;
    assign rx_baud_tick = rx_tick_q;
    assign tx_baud_tick = tx_tick_q;
    assign ext_int_a_req = exta_req_q;
    assign ext_int_b_req = extb_req_q;
    assign t2_irq_req = t2_req_q;
    assign irq = irq_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    t1_ovf_set_a: assert property (
        events.t1_ovf |=> tc_q[`TC_T1_OVF])
        else $error("timer 1 overflow flag not set");
    t0_ack_clr_a: assert property (
        acks.t0_ack && !events.t0_ovf && !wr_tc |=> !tc_q[`TC_T0_OVF])
        else $error("timer 0 overflow flag not cleared on vector");
    run_follow_a: assert property (
        wr_tc |=> ##1 t0_run == $past(writedata[`TC_T0_RUN], 2))
        else $error("timer 0 run output wrong");
    extb_edge_a: assert property (
        tc_q[`TC_EXTB_TYPE] && extb_edge && !wr_tc |=> tc_q[`TC_EXTB_FLAG])
        else $error("interrupt b edge not flagged");
    exta_fall_a: assert property (
        tc_q[`TC_EXTA_TYPE] && exta_fall && !wr_tc |=> tc_q[`TC_EXTA_FLAG])
        else $error("interrupt a fall not flagged");
    t2_baud_ovf_a: assert property (
        baud_mode && !t2c_q[`T2_OVF] && !wr_t2c |=> !t2c_q[`T2_OVF])
        else $error("timer 2 overflow flag set in baud mode");
    ext_toggle_a: assert property (
        t2_ext_tog && !t2_ext_set && !wr_t2c
        |=> t2c_q[`T2_EXT] != $past(t2c_q[`T2_EXT]))
        else $error("external flag did not toggle");
    rx_baud_sel_a: assert property (
        ##1 rx_baud_tick == ($past(t2c_q[`T2_RX_SEL])
        ? $past(events.t2_ovf) : $past(events.t1_ovf)))
        else $error("receive baud source wrong");
    trig_ignore_a: assert property (
        !t2c_q[`T2_TRIG_EN] |=> !t2_capture_pulse && !t2_reload_pulse)
        else $error("trigger acted while disabled");
    t2_irq_req_a: assert property (
        (t2c_q[`T2_OVF] || t2c_q[`T2_EXT]) |=> t2_irq_req)
        else $error("timer 2 request missing");
    bus_answer_a: assert property ((read || write) && waitrequest
        |=> !waitrequest)
        else $error("bus request not answered");
    irq_level_a: assert property (##1 irq == |($past(irq_stat_q)
        & $past(irq_mask_q)))
        else $error("interrupt output wrong");

    capture_c: cover property (t2_capture_pulse);
    reload_c: cover property (t2_reload_pulse);
    toggle_c: cover property (t2_ext_tog ##1 t2_irq_req);
    extb_both_c: cover property (extb_edge ##[1:20] extb_edge);

endmodule

`default_nettype wire

// ==== logic/timer_ctl_defines.svh ====
// register map, bit positions and reset values of the timer control block
`ifndef TIMER_CTL_DEFINES_SVH
`define TIMER_CTL_DEFINES_SVH

// byte addresses of the 32-bit register words
`define ADDR_TIMER_CONTROL 5'h00
`define ADDR_TIMER2_CONTROL 5'h04
`define ADDR_T2_MODE 5'h08
`define ADDR_IRQ_STATUS 5'h0C
`define ADDR_IRQ_MASK 5'h10

// timer_control fields
`define TC_T1_OVF 7
`define TC_T1_RUN 6
`define TC_T0_OVF 5
`define TC_T0_RUN 4
`define TC_EXTB_FLAG 3
`define TC_EXTB_TYPE 2
`define TC_EXTA_FLAG 1
`define TC_EXTA_TYPE 0

// timer2_control fields
`define T2_OVF 7
`define T2_EXT 6
`define T2_RX_SEL 5
`define T2_TX_SEL 4
`define T2_TRIG_EN 3
`define T2_RUN 2
`define T2_CNT_SEL 1
`define T2_CAP_SEL 0

// t2_mode fields
`define T2M_UPDOWN 0
`define T2M_CLKOUT 1

// interrupt status and mask fields
`define IRQ_T0 0
`define IRQ_T1 1
`define IRQ_T2_OVF 2
`define IRQ_T2_EXT 3
`define IRQ_EXTA 4
`define IRQ_EXTB 5
`define IRQ_W 6

// reset values
`define RST_TC 8'h00
`define RST_T2C 8'h00
`define RST_T2M 2'h0
`define RST_IRQ 6'h00

`endif

// ==== logic/timer_ctl_pkg.sv ====
// types shared by the timer control block
package timer_ctl_pkg;

    // one-cycle pulses from the counter datapaths
    typedef struct packed {
        logic t0_ovf;
        logic t1_ovf;
        logic t2_ovf;
        logic t2_udf;
    } timer_events_t;

    // one-cycle pulses from the processor when it vectors to a routine
    typedef struct packed {
        logic t0_ack;
        logic t1_ack;
        logic exta_ack;
        logic extb_ack;
    } vector_acks_t;

    // timer 2 operating mode as seen by the flag logic
    typedef enum logic [1:0] {
        T2_MODE_CAPTURE = 2'b00,
        T2_MODE_RELOAD = 2'b01,
        T2_MODE_RELOAD_UD = 2'b10,
        T2_MODE_OTHER = 2'b11
    } t2_mode_t;

endpackage

// ==== verif/vector_model.sv ====
// processor side that vectors to one external interrupt request
`timescale 1ns/1ps
`default_nettype none

module vector_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // bench control
    input wire logic en,
    input wire logic [3:0] delay,
    // request and acknowledge
    input wire logic req,
    output logic ack
);
    int cnt;

    always_ff @(posedge ref_clk) begin
        if (rst || !en) begin
            cnt <= 0;
            ack <= 1'b0;
        end else if (cnt < 0) begin
            // hold off until the served request has had time to drop
            cnt <= cnt + 1;
            ack <= 1'b0;
        end else if (!req) begin
            cnt <= 0;
            ack <= 1'b0;
        end else if (cnt == int'(delay)) begin
            ack <= 1'b1;
            cnt <= -6;
        end else begin
            cnt <= cnt + 1;
            ack <= 1'b0;
        end
    end
endmodule

`default_nettype wire

// ==== verif/timer_control_status_bits_tb.sv ====
// self-checking bench for the timer control and status block
`timescale 1ns/1ps
`default_nettype none
`include "timer_ctl_defines.svh"

module timer_control_status_bits_tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] address = 5'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    timer_ctl_pkg::timer_events_t events = '0;
    logic t0_ack = 1'b0;
    logic t1_ack = 1'b0;
    logic exta_ack, extb_ack;
    logic pin_a = 1'b1;
    logic pin_b = 1'b1;
    logic trig = 1'b1;
    logic t0_run, t1_run, t2_run, t2_cnt, cap_p, rel_p, rx_t, tx_t;
    logic req_a, req_b, t2_irq, irq;
    logic auto_en = 1'b0;
    logic [3:0] dly = 4'h0;
    logic [7:0] m_tc = 8'h00;
    logic [7:0] m_t2c = 8'h00;
    logic [31:0] q;
    logic [31:0] ev;
    int fail_count = 0;
    int tests_run = 0;
    int n_rx = 0;
    int n_tx = 0;
    int n_cap = 0;
    int n_rel = 0;
    // {enable, capture, updown, clock-out, ext flag, capture, reload}
    localparam logic [6:0] TRIG_TAB [5] = '{7'h20, 7'h66, 7'h45,
        7'h50, 7'h4C};

    timer_ctl u_timer_ctl (
        .ref_clk(ref_clk), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .events(events),
        .acks({t0_ack, t1_ack, exta_ack, extb_ack}),
        .ext_int_a_pin(pin_a), .ext_int_b_pin(pin_b),
        .t2_trigger_input(trig), .t0_run(t0_run), .t1_run(t1_run),
        .t2_run(t2_run), .t2_counter_mode(t2_cnt),
        .t2_capture_pulse(cap_p), .t2_reload_pulse(rel_p),
        .rx_baud_tick(rx_t), .tx_baud_tick(tx_t), .ext_int_a_req(req_a),
        .ext_int_b_req(req_b), .t2_irq_req(t2_irq), .irq(irq)
    );
    vector_model u_vector_a (.ref_clk(ref_clk), .rst(rst), .en(auto_en),
        .delay(dly), .req(req_a), .ack(exta_ack));
    vector_model u_vector_b (.ref_clk(ref_clk), .rst(rst), .en(auto_en),
        .delay(dly), .req(req_b), .ack(extb_ack));

    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    // pulse outputs are counted so a missing or doubled pulse shows
    always @(posedge ref_clk) begin
        if (rx_t === 1'b1) n_rx <= n_rx + 1;
        if (tx_t === 1'b1) n_tx <= n_tx + 1;
        if (cap_p === 1'b1) n_cap <= n_cap + 1;
        if (rel_p === 1'b1) n_rel <= n_rel + 1;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic timed_out();
        fail_count++;
        wrap_up();
    endtask

    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        tests_run++;
        if (got !== exp)
            $display("wrong value %s expected %h seen %h", what, exp, got);
        if (got !== exp)
            fail_count++;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
    endtask

    // holds the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a,
        input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        address <= a;
        read <= ~wr;
        write <= wr;
        writedata <= d;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 40);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 40)
            timed_out();
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d});
        if (a == `ADDR_TIMER_CONTROL) m_tc = d;
        if (a == `ADDR_TIMER2_CONTROL) m_t2c = d;
    endtask

    task automatic rd(input string what, input logic [4:0] a,
        input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(what, exp, q);
    endtask

    task automatic pulse(input logic [3:0] d);
        @(posedge ref_clk);
        events <= timer_ctl_pkg::timer_events_t'(d);
        @(posedge ref_clk);
        events <= '0;
        cyc(4);
    endtask

    task automatic wait_req(input int w, input logic v);
        int n;
        n = 0;
        while ((w != 0 ? req_b : req_a) !== v && n < 40) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 40)
            timed_out();
    endtask

    initial begin
        repeat (60000) @(posedge ref_clk);
        timed_out();
    end

    initial begin
        void'($urandom(11876));
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        cyc(3);
        rd("tc reset", `ADDR_TIMER_CONTROL, 32'h0);
        rd("t2c reset", `ADDR_TIMER2_CONTROL, 32'h0);
        wr(5'h14, 8'hFF);
        rd("unmapped", 5'h14, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            wr(`ADDR_TIMER_CONTROL, 8'($urandom) & 8'h55);
            wr(`ADDR_TIMER2_CONTROL, 8'($urandom) & 8'h37);
            cyc(3);
            check("t0_run", 32'(m_tc[4]), 32'(t0_run));
            check("t1_run", 32'(m_tc[6]), 32'(t1_run));
            check("t2_run", 32'(m_t2c[2]), 32'(t2_run));
            check("t2_cnt", 32'(m_t2c[1]), 32'(t2_cnt));
            rd("t2c", `ADDR_TIMER2_CONTROL, 32'(m_t2c));
        end
        $display("test run bits done");
        wr(`ADDR_TIMER_CONTROL, 8'h00);
        for (int i = 0; i < 2; i++) begin
            pulse(i != 0 ? 4'h4 : 4'h8);
            ev = i != 0 ? 32'h80 : 32'h20;
            rd("ovf set", `ADDR_TIMER_CONTROL, ev);
            @(posedge ref_clk);
            {t0_ack, t1_ack} <= i != 0 ? 2'b01 : 2'b10;
            @(posedge ref_clk);
            {t0_ack, t1_ack} <= 2'b00;
            rd("ovf served", `ADDR_TIMER_CONTROL, 32'h0);
        end
        rd("status", `ADDR_IRQ_STATUS, 32'h3);
        check("irq masked", 32'h0, 32'(irq));
        wr(`ADDR_IRQ_MASK, 8'h3F);
        cyc(3);
        check("irq", 32'h1, 32'(irq));
        wr(`ADDR_IRQ_STATUS, 8'h03);
        cyc(3);
        check("irq cleared", 32'h0, 32'(irq));
        $display("test overflow done");
        for (int i = 0; i < 4; i++) begin
            int r0;
            int x0;
            wr(`ADDR_TIMER2_CONTROL, 8'(i << 4));
            r0 = n_rx;
            x0 = n_tx;
            pulse(4'h2);
            check("rx t2", 32'(i[1]), 32'(n_rx - r0));
            check("tx t2", 32'(i[0]), 32'(n_tx - x0));
            r0 = n_rx;
            x0 = n_tx;
            pulse(4'h4);
            check("rx t1", 32'(!i[1]), 32'(n_rx - r0));
            check("tx t1", 32'(!i[0]), 32'(n_tx - x0));
            ev = 32'(i << 4) | (i == 0 ? 32'h80 : 32'h0);
            rd("t2 ovf", `ADDR_TIMER2_CONTROL, ev);
            check("t2 irq", 32'(i == 0), 32'(t2_irq));
        end
        wr(`ADDR_TIMER2_CONTROL, 8'h00);
        cyc(3);
        check("t2 irq clear", 32'h0, 32'(t2_irq));
        $display("test baud done");
        wr(`ADDR_TIMER_CONTROL, 8'h05);
        for (int i = 0; i < 4; i++) begin
            int w;
            logic lv;
            logic e;
            w = i % 2;
            lv = i[1];
            e = !lv || w != 0;
            if (w != 0) pin_b <= lv;
            else pin_a <= lv;
            cyc(8);
            ev = 32'h05 | (e ? (w != 0 ? 32'h08 : 32'h02) : 32'h0);
            rd("edge", `ADDR_TIMER_CONTROL, ev);
            if (e) begin
                dly <= 4'($urandom % 6);
                auto_en <= 1'b1;
                wait_req(w, 1'b0);
                auto_en <= 1'b0;
                rd("served", `ADDR_TIMER_CONTROL, 32'h05);
            end
        end
        for (int w = 0; w < 2; w++) begin
            wr(`ADDR_TIMER_CONTROL, 8'h00);
            if (w != 0) pin_b <= 1'b0;
            else pin_a <= 1'b0;
            cyc(8);
            ev = w != 0 ? 32'h08 : 32'h02;
            rd("level", `ADDR_TIMER_CONTROL, ev);
            if (w != 0) pin_b <= 1'b1;
            else pin_a <= 1'b1;
            cyc(8);
            rd("level gone", `ADDR_TIMER_CONTROL, 32'h0);
        end
        $display("test external done");
        for (int i = 0; i < 5; i++) begin
            logic [6:0] tv;
            int c0;
            int r0;
            tv = TRIG_TAB[i];
            wr(`ADDR_T2_MODE, {6'h0, tv[3], tv[4]});
            wr(`ADDR_TIMER2_CONTROL, {4'h0, tv[6], 2'h0, tv[5]});
            c0 = n_cap;
            r0 = n_rel;
            trig <= 1'b0;
            cyc(8);
            check("capture", 32'(tv[1]), 32'(n_cap - c0));
            check("reload", 32'(tv[0]), 32'(n_rel - r0));
            ev = {25'h0, tv[2], 2'h0, tv[6], 2'h0, tv[5]};
            rd("ext", `ADDR_TIMER2_CONTROL, ev);
            check("t2 irq ext", 32'(tv[2]), 32'(t2_irq));
            trig <= 1'b1;
            cyc(6);
            wr(`ADDR_TIMER2_CONTROL, 8'h00);
        end
        $display("test trigger done");
        wr(`ADDR_T2_MODE, 8'h01);
        for (int i = 0; i < 3; i++) begin
            pulse(i == 1 ? 4'h1 : 4'h2);
            bus(1'b0, `ADDR_TIMER2_CONTROL, 32'h0);
            check("toggle", i == 1 ? 32'h0 : 32'h40, q & 32'h40);
        end
        wr(`ADDR_IRQ_STATUS, 8'h3F);
        rd("status w1c", `ADDR_IRQ_STATUS, 32'h0);
        $display("test toggle done");
        wrap_up();
    end
endmodule

`default_nettype wire
